/* crs_rx_steer.sv */
// Receive buffer steering, flags and buffer-full pins
`timescale 1ns/1ns

// Overview of operation
// [R1] Pin enable zero puts that buffer-full pin in high impedance.
// [R2] Enable and mode one: pin low while the buffer's loaded flag is set.
// [R3] Enable one, mode zero: pin drives the pin-state bit level.
// [R4] Host should change pin-state bits with the masked write command.
// [R5] Pin-state bit reads zero while its pin is in interrupt mode.
// [R6] Assemble on start of message; invalid message raises error frame.
// [R7] Test buffer zero filters first, buffer one filters only on miss.
// [R8] Buffer zero full with rollover on sends message to buffer one.
// [R9] Buffer zero full, rollover off: discard, set overflow bit 6.
// [R10] Buffer one full: discard, set overflow bit 7.
// [R11] Load into zero sets flag bit 0 and filter-hit bit.
// [R12] Load into one sets flag bit 3 and three-bit filter-hit code.
// [R13] Overflow with error interrupt enable bit 5 asserts interrupt.
// [R14] Loaded buffer with its receive interrupt enable asserts interrupt.
// [R15] Low four status bits show which buffer was loaded.
// [R16] Mode 11 accepts any message; mode 00 needs a filter match.
// [R17] Standard frames filter data bytes 0 and 1 with extended bits.
// [R18] Host must not program receive mode 10 or 01.
// [R19] Control bit 3 reads one when stored message was remote request.
// [R20] Buffer zero bit 2 enables rollover, bit 1 mirrors it read-only.
// [R21] Filter-hit bit 1 means filter one, updated on rollover.
// [R22] Buffer one codes filters 5..0 as 101..000; 001/000 only on rollover.
// [R23] Host clears loaded flag when done; buffer is locked until then.
// [R24] Mask zero accepts bit; mask one needs filter bit equal message bit.
module crs_rx_steer (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    // Protocol engine side
    input wire logic sof_i,
    input wire logic msg_done_i,
    input wire logic msg_valid_i,
    input wire crs_pkg::crs_msg_t msg_i,
    output logic error_frame_o,
    // Filters and masks
    input wire crs_pkg::crs_filter_t [crs_pkg::NUM_FILTERS-1:0] filters_i,
    input wire logic [28:0] mask0_i,
    input wire logic [28:0] mask1_i,
    // Serial register port
    input wire crs_pkg::crs_reg_req_t req_i,
    output logic [7:0] rdata_o,
    // Buffer moves and interrupt
    output logic load0_o,
    output logic load1_o,
    output logic assembling_o,
    output logic irq_n_o,
    // Buffer-full pins
    output logic buf0_full_pin_n_o,
    output logic buf0_full_pin_oe_o,
    output logic buf1_full_pin_n_o,
    output logic buf1_full_pin_oe_o
);
    logic [7:0] bfp_reg;
    logic [1:0] mode0_reg;
    logic [1:0] mode1_reg;
    logic rollover_enable_reg;
    logic rtr0_reg;
    logic rtr1_reg;
    logic filter_hit_lsb_reg;
    logic [2:0] filter_hit_code_reg;
    logic [7:0] irq_enable_reg;
    logic [1:0] rx_loaded_flag_reg;
    logic [1:0] overflow_reg;
    logic [3:0] status_reg;
    logic assembling_reg;
    logic error_frame_reg;
    logic [crs_pkg::NUM_FILTERS-1:0] hit;
    logic acc0;
    logic acc1;
    logic done;
    logic to0;
    logic to1;
    logic roll;
    logic ovr0;
    logic ovr1;
    logic [2:0] code_next;
    logic [7:0] wr_old;
    logic [7:0] wr_next;

    // ------------------------------------------------------------------
    // Filter bank
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < crs_pkg::NUM_FILTERS; gi++) begin : g_filt
            crs_filter_match u_match (
                .msg_i(msg_i),
                .filt_i(filters_i[gi]),
                .mask_i((gi < 2) ? mask0_i : mask1_i),
                .hit_o(hit[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Steering decision
    // ------------------------------------------------------------------
    always_comb begin
        done = assembling_reg && msg_done_i && msg_valid_i;
        acc0 = (mode0_reg == crs_pkg::MODE_ANY) || (|hit[1:0]); // [R16]
        acc1 = (mode1_reg == crs_pkg::MODE_ANY) || (|hit[5:2]); // [R16]
        to0 = 1'b0;
        to1 = 1'b0;
        roll = 1'b0;
        ovr0 = 1'b0;
        ovr1 = 1'b0;
        if (done && acc0) begin // [R7]
            if (!rx_loaded_flag_reg[0]) begin
                to0 = 1'b1;
            end else if (rollover_enable_reg) begin
                roll = 1'b1; // [R8]
            end else begin
                ovr0 = 1'b1; // [R9]
            end
        end else if (done && acc1) begin
            to1 = 1'b1;
        end
        if (roll || to1) begin
            if (rx_loaded_flag_reg[1]) begin
                to1 = 1'b0;
                ovr1 = 1'b1; // [R10]
            end else begin
                to1 = 1'b1;
            end
        end
        // Lowest numbered matching filter wins inside each buffer
        if (roll) begin
            code_next = hit[0] ? 3'h0 : 3'h1; // [R22]
        end else if (hit[2]) begin
            code_next = 3'h2;
        end else if (hit[3]) begin
            code_next = 3'h3;
        end else if (hit[4]) begin
            code_next = 3'h4;
        end else begin
            code_next = 3'h5; // [R22]
        end
        // Masked write: only bits with mask one change; read-only bits are dropped later
        case (req_i.addr)
            crs_pkg::BFP_CTRL_ADDR: wr_old = bfp_reg;
            crs_pkg::IRQ_EN_ADDR: wr_old = irq_enable_reg;
            crs_pkg::IRQ_FLAG_ADDR: begin
                wr_old = 8'h00;
                wr_old[crs_pkg::IF_RX0_BIT] = rx_loaded_flag_reg[0];
                wr_old[crs_pkg::IF_RX1_BIT] = rx_loaded_flag_reg[1];
            end
            crs_pkg::ERR_FLAG_ADDR: wr_old = {overflow_reg, 6'h00};
            crs_pkg::RX_SLOT_ZERO_CTRL_ADDR: wr_old = {1'b0, mode0_reg, 2'h0, rollover_enable_reg, 2'h0};
            crs_pkg::RX_SLOT_ONE_CTRL_ADDR: wr_old = {1'b0, mode1_reg, 5'h00};
            default: wr_old = 8'h00;
        endcase
        wr_next = (wr_old & ~req_i.wmask) | (req_i.wdata & req_i.wmask);
    end

    assign load0_o = to0;
    assign load1_o = to1;

    // ------------------------------------------------------------------
    // Assembly tracking and error frame
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            assembling_reg <= 1'b0;
            error_frame_reg <= 1'b0;
        end else begin
            // An end and a new start in one cycle must still flag the old message
            error_frame_reg <= assembling_reg && msg_done_i && !msg_valid_i; // [R6]
            if (sof_i) begin
                assembling_reg <= 1'b1; // [R6]
            end else if (msg_done_i) begin
                assembling_reg <= 1'b0;
            end
        end
    end

    assign assembling_o = assembling_reg;
    assign error_frame_o = error_frame_reg;

    // ------------------------------------------------------------------
    // Host writes
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bfp_reg <= crs_pkg::REG_RESET;
            irq_enable_reg <= crs_pkg::REG_RESET;
            mode0_reg <= crs_pkg::MODE_FILTERED;
            mode1_reg <= crs_pkg::MODE_FILTERED;
            rollover_enable_reg <= 1'b0;
        end else if (req_i.wr) begin
            case (req_i.addr)
                crs_pkg::BFP_CTRL_ADDR: begin
                    bfp_reg <= wr_next & 8'h3F; // [R4]
                end
                crs_pkg::IRQ_EN_ADDR: begin
                    irq_enable_reg <= wr_next;
                end
                crs_pkg::RX_SLOT_ZERO_CTRL_ADDR: begin
                    mode0_reg <= wr_next[crs_pkg::RXC_MODE_LSB +: 2];
                    rollover_enable_reg <= wr_next[crs_pkg::RXC_ROLL_BIT]; // [R20]
                end
                crs_pkg::RX_SLOT_ONE_CTRL_ADDR: begin
                    mode1_reg <= wr_next[crs_pkg::RXC_MODE_LSB +: 2];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Loaded flags and overflow: hardware set wins over host clear
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rx_loaded_flag_reg <= 2'h0;
            overflow_reg <= 2'h0;
        end else begin
            if (req_i.wr && req_i.addr == crs_pkg::IRQ_FLAG_ADDR) begin
                rx_loaded_flag_reg[0] <= wr_next[crs_pkg::IF_RX0_BIT] | to0;
                rx_loaded_flag_reg[1] <= wr_next[crs_pkg::IF_RX1_BIT] | to1;
            end else begin
                rx_loaded_flag_reg <= rx_loaded_flag_reg | {to1, to0}; // [R11] [R12] [R23]
            end
            if (req_i.wr && req_i.addr == crs_pkg::ERR_FLAG_ADDR) begin
                overflow_reg <= {wr_next[crs_pkg::EF_RX1_OVR_BIT],
                    wr_next[crs_pkg::EF_RX0_OVR_BIT]} | {ovr1, ovr0};
            end else begin
                overflow_reg <= overflow_reg | {ovr1, ovr0}; // [R9] [R10]
            end
        end
    end

    // ------------------------------------------------------------------
    // Per-buffer message status
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rtr0_reg <= 1'b0;
            rtr1_reg <= 1'b0;
            filter_hit_lsb_reg <= 1'b0;
            filter_hit_code_reg <= 3'h0;
            status_reg <= 4'h0;
        end else begin
            if (to0) begin
                rtr0_reg <= msg_i.rtr; // [R19]
                filter_hit_lsb_reg <= !hit[0]; // [R11] [R21]
                status_reg <= crs_pkg::STAT_SLOT0; // [R15]
            end
            if (to1) begin
                rtr1_reg <= msg_i.rtr; // [R19]
                filter_hit_code_reg <= code_next; // [R12]
                status_reg <= crs_pkg::STAT_SLOT1; // [R15]
                if (roll) begin
                    filter_hit_lsb_reg <= code_next[0]; // [R21]
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt output
    // ------------------------------------------------------------------
    always_comb begin
        irq_n_o = !((rx_loaded_flag_reg[0] && irq_enable_reg[crs_pkg::IE_RX0_BIT]) // [R14]
            || (rx_loaded_flag_reg[1] && irq_enable_reg[crs_pkg::IE_RX1_BIT]) // [R14]
            || ((|overflow_reg) && irq_enable_reg[crs_pkg::IE_ERR_BIT])); // [R13]
    end

    // ------------------------------------------------------------------
    // Buffer-full pins
    // ------------------------------------------------------------------
    always_comb begin
        buf0_full_pin_oe_o = bfp_reg[crs_pkg::BFP_EN_LSB]; // [R1]
        buf1_full_pin_oe_o = bfp_reg[crs_pkg::BFP_EN_LSB + 1]; // [R1]
        if (bfp_reg[crs_pkg::BFP_MODE_LSB]) begin
            buf0_full_pin_n_o = !rx_loaded_flag_reg[0]; // [R2]
        end else begin
            buf0_full_pin_n_o = bfp_reg[crs_pkg::BFP_LVL_LSB]; // [R3]
        end
        if (bfp_reg[crs_pkg::BFP_MODE_LSB + 1]) begin
            buf1_full_pin_n_o = !rx_loaded_flag_reg[1]; // [R2]
        end else begin
            buf1_full_pin_n_o = bfp_reg[crs_pkg::BFP_LVL_LSB + 1]; // [R3]
        end
    end

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    always_comb begin
        case (req_i.addr)
            crs_pkg::BFP_CTRL_ADDR: begin
                rdata_o = bfp_reg & ~{2'h0, bfp_reg[1:0], 4'h0}; // [R5]
            end
            crs_pkg::IRQ_EN_ADDR: begin
                rdata_o = irq_enable_reg;
            end
            crs_pkg::IRQ_FLAG_ADDR: begin
                rdata_o = {4'h0, rx_loaded_flag_reg[1], 2'h0, rx_loaded_flag_reg[0]}; // [R12]
            end
            crs_pkg::ERR_FLAG_ADDR: begin
                rdata_o = {overflow_reg, 6'h00};
            end
            crs_pkg::CTRL_STATUS_ADDR: begin
                rdata_o = {4'h0, status_reg};
            end
            crs_pkg::RX_SLOT_ZERO_CTRL_ADDR: begin
                rdata_o = {1'b0, mode0_reg, 1'b0, rtr0_reg, rollover_enable_reg,
                    rollover_enable_reg, filter_hit_lsb_reg}; // [R20]
            end
            crs_pkg::RX_SLOT_ONE_CTRL_ADDR: begin
                rdata_o = {1'b0, mode1_reg, 1'b0, rtr1_reg, filter_hit_code_reg};
            end
            default: begin
                rdata_o = 8'h00;
            end
        endcase
    end

endmodule // crs_rx_steer

/* crs_pkg.sv */
// Package: register map, field layout and carriers of the receive steering block
package crs_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] BFP_CTRL_ADDR = 8'h0C;
    localparam logic [7:0] IRQ_EN_ADDR = 8'h2B;
    localparam logic [7:0] IRQ_FLAG_ADDR = 8'h2C;
    localparam logic [7:0] ERR_FLAG_ADDR = 8'h2D;
    localparam logic [7:0] CTRL_STATUS_ADDR = 8'h0E;
    localparam logic [7:0] RX_SLOT_ZERO_CTRL_ADDR = 8'h60;
    localparam logic [7:0] RX_SLOT_ONE_CTRL_ADDR = 8'h70;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BFP_MODE_LSB = 0;
    localparam int BFP_EN_LSB = 2;
    localparam int BFP_LVL_LSB = 4;
    localparam int RXC_MODE_LSB = 5;
    localparam int RXC_RTR_BIT = 3;
    localparam int RXC_ROLL_BIT = 2;
    localparam int RXC_ROLL_COPY_BIT = 1;
    localparam int IF_RX0_BIT = 0;
    // Loaded flags sit at bits 0 and 3, their enables at bits 0 and 1
    localparam int IF_RX1_BIT = 3;
    localparam int IE_RX0_BIT = 0;
    localparam int IE_RX1_BIT = 1;
    localparam int IE_ERR_BIT = 5;
    localparam int EF_RX0_OVR_BIT = 6;
    localparam int EF_RX1_OVR_BIT = 7;

    // ------------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [1:0] MODE_FILTERED = 2'h0;
    localparam logic [1:0] MODE_ANY = 2'h3;
    localparam logic [3:0] STAT_SLOT0 = 4'hC;
    localparam logic [3:0] STAT_SLOT1 = 4'hE;
    localparam int NUM_FILTERS = 6;

    // Identifier and first two data bytes as seen by the filters
    typedef struct packed {
        logic [10:0] sid;
        logic [17:0] eid;
        logic ext;
        logic rtr;
        logic [15:0] data01;
    } crs_msg_t;

    // Serial register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] wmask;
    } crs_reg_req_t;

    // Filter and mask values, each a full 29-bit identifier pattern
    typedef struct packed {
        logic [28:0] value;
        logic ext_only;
    } crs_filter_t;

endpackage

/* crs_filter_match.sv */
// One acceptance filter compared against the assembled message
`timescale 1ns/1ns
module crs_filter_match (
    // Message and patterns
    input wire crs_pkg::crs_msg_t msg_i,
    input wire crs_pkg::crs_filter_t filt_i,
    input wire logic [28:0] mask_i,
    // Result
    output logic hit_o
);
    logic [28:0] id_bits;
    logic ext_ok;

    // Standard frames reuse the extended filter bits on data bytes 0 and 1
    always_comb begin
        if (msg_i.ext) begin
            id_bits = {msg_i.sid, msg_i.eid};
        end else begin
            id_bits = {msg_i.sid, 2'h0, msg_i.data01}; // [R17]
        end
        ext_ok = (filt_i.ext_only == msg_i.ext);
    end

    // Mask zero passes the bit; mask one needs filter equal to message
    always_comb begin
        hit_o = ext_ok && (((id_bits ^ filt_i.value) & mask_i) == 29'h0); // [R24]
    end

endmodule // crs_filter_match

/* crs_rx_steer_properties.sv */
// Checker: port relations of the receive steering block
`timescale 1ns/1ns
module crs_rx_steer_properties (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    // Engine and register port
    input wire logic sof_i,
    input wire logic msg_done_i,
    input wire logic msg_valid_i,
    input wire crs_pkg::crs_reg_req_t req_i,
    // Watched outputs
    input wire logic error_frame_o,
    input wire logic load0_o,
    input wire logic load1_o,
    input wire logic assembling_o,
    input wire logic irq_n_o,
    input wire logic buf0_full_pin_n_o,
    input wire logic buf0_full_pin_oe_o,
    input wire logic buf1_full_pin_n_o,
    input wire logic buf1_full_pin_oe_o
);
    logic [7:0] bfp_reg;
    logic [7:0] ie_reg;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    // ----------------------------------------------------------------
    // Shadows of the writable registers the pins and irq depend on
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bfp_reg <= 8'h00;
        end else if (req_i.wr && req_i.addr == crs_pkg::BFP_CTRL_ADDR) begin
            bfp_reg <= (bfp_reg & ~req_i.wmask) | (req_i.wdata & req_i.wmask);
        end
    end
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ie_reg <= 8'h00;
        end else if (req_i.wr && req_i.addr == crs_pkg::IRQ_EN_ADDR) begin
            ie_reg <= (ie_reg & ~req_i.wmask) | (req_i.wdata & req_i.wmask);
        end
    end
    a_pin0_hiz_off: assert property (!bfp_reg[2] |-> !buf0_full_pin_oe_o)
        else $error("pin 0 driven while disabled");
    a_pin1_hiz_off: assert property (!bfp_reg[3] |-> !buf1_full_pin_oe_o)
        else $error("pin 1 driven while disabled");
    a_pin0_out_level: assert property (
        bfp_reg[2] && !bfp_reg[0] |-> buf0_full_pin_oe_o && buf0_full_pin_n_o == bfp_reg[4])
        else $error("pin 0 output level wrong");
    a_pin1_out_level: assert property (
        bfp_reg[3] && !bfp_reg[1] |-> buf1_full_pin_oe_o && buf1_full_pin_n_o == bfp_reg[5])
        else $error("pin 1 output level wrong");
    a_pin0_full_low: assert property (
        load0_o && bfp_reg[2] && bfp_reg[0] |=> buf0_full_pin_oe_o && !buf0_full_pin_n_o)
        else $error("pin 0 not low after load");
    a_pin1_full_low: assert property (
        load1_o && bfp_reg[3] && bfp_reg[1] |=> buf1_full_pin_oe_o && !buf1_full_pin_n_o)
        else $error("pin 1 not low after load");
    a_load_cause: assert property (load0_o || load1_o |-> msg_done_i && msg_valid_i)
        else $error("load without valid end of message");
    a_load_single: assert property (!(load0_o && load1_o))
        else $error("message loaded into both buffers");
    a_err_frame: assert property (
        msg_done_i && !msg_valid_i && assembling_o |=> error_frame_o)
        else $error("no error frame for invalid message");
    a_start_asm: assert property (sof_i |=> assembling_o)
        else $error("start of message did not begin assembly");
    a_irq_on_load: assert property (
        (load0_o && ie_reg[0]) || (load1_o && ie_reg[1]) |=> !irq_n_o)
        else $error("no interrupt after enabled load");
endmodule // crs_rx_steer_properties

bind crs_rx_steer crs_rx_steer_properties crs_rx_steer_properties_inst (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .sof_i(sof_i),
    .msg_done_i(msg_done_i),
    .msg_valid_i(msg_valid_i),
    .req_i(req_i),
    .error_frame_o(error_frame_o),
    .load0_o(load0_o),
    .load1_o(load1_o),
    .assembling_o(assembling_o),
    .irq_n_o(irq_n_o),
    .buf0_full_pin_n_o(buf0_full_pin_n_o),
    .buf0_full_pin_oe_o(buf0_full_pin_oe_o),
    .buf1_full_pin_n_o(buf1_full_pin_n_o),
    .buf1_full_pin_oe_o(buf1_full_pin_oe_o)
);

/* crs_host_model.sv */
// Host model driving the serial register port
`timescale 1ns/1ns
module crs_host_model (
    // Clock
    input wire logic ref_clk_i,
    // Register port
    output crs_pkg::crs_reg_req_t req_o,
    input wire logic [7:0] rdata_i
);
    initial begin
        req_o = '0;
    end
    // Every write is masked, so pin-state bits change without glitches
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
        @(negedge ref_clk_i);
        req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d, wmask: m};
        @(negedge ref_clk_i);
        req_o.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk_i);
        req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00, wmask: 8'h00};
        @(posedge ref_clk_i);
        d = rdata_i;
        // Release off the sampling edge so callers resume with settled outputs
        @(negedge ref_clk_i);
        req_o.rd = 1'b0;
    endtask
endmodule // crs_host_model

/* tb_top.sv */
// Testbench: register and message scenarios for the steering block
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
    $display("Error t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
    localparam logic [7:0] A_BFP = crs_pkg::BFP_CTRL_ADDR;
    localparam logic [7:0] A_IE = crs_pkg::IRQ_EN_ADDR;
    localparam logic [7:0] A_IF = crs_pkg::IRQ_FLAG_ADDR;
    localparam logic [7:0] A_EF = crs_pkg::ERR_FLAG_ADDR;
    localparam logic [7:0] A_ST = crs_pkg::CTRL_STATUS_ADDR;
    localparam logic [7:0] A_RX0 = crs_pkg::RX_SLOT_ZERO_CTRL_ADDR;
    localparam logic [7:0] A_RX1 = crs_pkg::RX_SLOT_ONE_CTRL_ADDR;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic sof = 1'b0;
    logic done = 1'b0;
    logic valid = 1'b0;
    logic [28:0] mask = 29'h1FFFFFFF;
    crs_pkg::crs_msg_t msg = '0;
    // Filter 0 all zero, 1 all ones extended, 3 all ones standard
    // Standard frames have no bits 17:16 to match, so filter 3 keeps them clear
    crs_pkg::crs_filter_t [crs_pkg::NUM_FILTERS-1:0] filt = {30'h1, 30'h1,
        {29'h1FFCFFFF, 1'b0}, 30'h1, {29'h1FFFFFFF, 1'b1}, 30'h0};
    crs_pkg::crs_reg_req_t req;
    logic [7:0] rdata;
    logic ef, load0, load1, asm, irq_n, p0, oe0, p1, oe1;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    crs_rx_steer crs_rx_steer_inst (.ref_clk_i(clk), .arst_n_i(arst_n), .sof_i(sof),
        .msg_done_i(done), .msg_valid_i(valid), .msg_i(msg), .error_frame_o(ef),
        .filters_i(filt), .mask0_i(mask), .mask1_i(mask), .req_i(req), .rdata_o(rdata),
        .load0_o(load0), .load1_o(load1), .assembling_o(asm), .irq_n_o(irq_n),
        .buf0_full_pin_n_o(p0), .buf0_full_pin_oe_o(oe0),
        .buf1_full_pin_n_o(p1), .buf1_full_pin_oe_o(oe1));
    crs_host_model crs_host_model_inst (.ref_clk_i(clk), .req_o(req), .rdata_i(rdata));
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic report_and_stop();
        $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Hangs are cut short well beyond the length of the sequence
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] d;
        crs_host_model_inst.rd(a, d);
        `CHK(d & m, e)
    endtask
    task automatic send(input logic x, input logic r, input logic o, input logic [15:0] d,
        input logic ok);
        @(negedge clk);
        msg = '{sid: {11{o}}, eid: {18{o}}, ext: x, rtr: r, data01: d};
        sof = 1'b1;
        @(negedge clk);
        sof = 1'b0;
        done = 1'b1;
        valid = ok;
        @(negedge clk);
        done = 1'b0;
        `CHK(ef, !ok)
    endtask
    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        `CHK({oe0, oe1, irq_n}, 3'h1)
        rchk(A_BFP, 8'hFF, 8'h00);
        rchk(A_RX0, 8'hFF, 8'h00);
        rchk(A_RX1, 8'hFF, 8'h00);
        crs_host_model_inst.wr(A_IE, 8'h23, 8'hFF);
        crs_host_model_inst.wr(A_BFP, 8'h3F, 8'hFF);
        rchk(A_BFP, 8'hFF, 8'h0F);
        // ----------------------------------------------------------------
        // Loads, overflow and rollover
        // ----------------------------------------------------------------
        send(1'b0, 1'b0, 1'b0, 16'h0000, 1'b1);
        `CHK({oe0, p0, irq_n}, 3'h4)
        rchk(A_IF, 8'h09, 8'h01);
        rchk(A_RX0, 8'hFF, 8'h00);
        rchk(A_ST, 8'h0F, {4'h0, crs_pkg::STAT_SLOT0});
        send(1'b1, 1'b0, 1'b1, 16'hFFFF, 1'b1);
        rchk(A_EF, 8'hC0, 8'h40);
        crs_host_model_inst.wr(A_IF, 8'h00, 8'h01);
        `CHK(p0, 1'b1)
        crs_host_model_inst.wr(A_RX0, 8'h04, 8'h04);
        rchk(A_RX0, 8'hFF, 8'h06);
        send(1'b0, 1'b0, 1'b0, 16'h0000, 1'b1);
        send(1'b1, 1'b0, 1'b1, 16'hFFFF, 1'b1);
        `CHK(p1, 1'b0)
        rchk(A_RX1, 8'hFF, 8'h01);
        rchk(A_RX0, 8'hFF, 8'h07);
        rchk(A_ST, 8'h0F, {4'h0, crs_pkg::STAT_SLOT1});
        send(1'b1, 1'b0, 1'b1, 16'hFFFF, 1'b1);
        rchk(A_EF, 8'hC0, 8'hC0);
        // Receive enables off, so only the overflow can hold the interrupt low
        crs_host_model_inst.wr(A_IE, 8'h00, 8'h03);
        `CHK(irq_n, 1'b0)
        crs_host_model_inst.wr(A_IF, 8'h00, 8'h09);
        `CHK(irq_n, 1'b0)
        crs_host_model_inst.wr(A_EF, 8'h00, 8'hC0);
        `CHK(irq_n, 1'b1)
        crs_host_model_inst.wr(A_RX0, 8'h00, 8'h04);
        send(1'b0, 1'b1, 1'b1, 16'hFFFF, 1'b1);
        rchk(A_RX1, 8'hFF, 8'h0B);
        rchk(A_IF, 8'h09, 8'h08);
        // ----------------------------------------------------------------
        // Data byte filtering, masks, errors, modes and pin outputs
        // ----------------------------------------------------------------
        send(1'b0, 1'b0, 1'b0, 16'h1234, 1'b1);
        rchk(A_IF, 8'h09, 8'h08);
        rchk(A_EF, 8'hC0, 8'h00);
        mask = 29'h00000000;
        send(1'b0, 1'b0, 1'b0, 16'h1234, 1'b1);
        rchk(A_IF, 8'h09, 8'h09);
        mask = 29'h1FFFFFFF;
        crs_host_model_inst.wr(A_IF, 8'h00, 8'h01);
        send(1'b0, 1'b0, 1'b0, 16'h0000, 1'b0);
        rchk(A_IF, 8'h09, 8'h08);
        crs_host_model_inst.wr(A_RX0, 8'h60, 8'h60);
        send(1'b0, 1'b0, 1'b1, 16'hFFFF, 1'b1);
        rchk(A_IF, 8'h09, 8'h09);
        crs_host_model_inst.wr(A_BFP, 8'h1C, 8'h3F);
        `CHK({oe0, p0, oe1, p1}, 4'hE)
        rchk(A_BFP, 8'hFF, 8'h1C);
        crs_host_model_inst.wr(A_BFP, 8'h00, 8'h10);
        `CHK({oe0, p0, oe1, p1}, 4'hA)
        report_and_stop();
    end
endmodule // tb_top
